// file: pll_pkg.sv
// constants, field layout and types shared by the synthesizer and its programming host
//
// Contract
// - device shifts serial data, 24 bits, rising edge
// - host sends most significant bit first
// - strobe rise copies word into one latch
// - bits one and zero pick the latch
// - 00 ref, 01 ab, 10 function, 11 init
// - 14-bit reference divider, ratios 1 to 16383
// - feedback divide N equals B times P plus A
// - B programmed only from 3 to 8191
// - A swallow counter takes 0 to 63
// - prescaler 8/9, 16/17, 32/33 or 64/65
// - host keeps N at least P squared minus P
// - host keeps prescaler output at most 300 MHz; the host logic makes no frequency check
// - phase compare with two-bit antibacklash width
// - monitor pin follows three-bit selector
// - precision 0: lock after three good cycles
// - precision 1: lock after five good cycles
// - lock drops on error above 25 ns
// - analog lock: open drain, narrow low pulses
// - power-down closes reference isolate switch
// - divider reset bit holds all counters
// - power-down loads counters, shifter keeps working
package pll_pkg;
  localparam int WORD_W = 24;
  localparam int R_W = 14;
  localparam int A_W = 6;
  localparam int B_W = 13;
  localparam int REF_DIV_LSB = 2;
  localparam int BACKLASH_LSB = 16;
  localparam int LOCK_PREC_BIT = 20;
  localparam int A_LSB = 2;
  localparam int B_LSB = 8;
  localparam int DIV_RESET_BIT = 2;
  localparam int PD1_BIT = 3;
  localparam int MON_LSB = 4;
  localparam int PD2_BIT = 21;
  localparam int PRESC_LSB = 22;
  localparam logic [R_W-1:0] REF_DIV_RST = 14'h0001;
  localparam logic [B_W-1:0] B_RST = 13'h0003;
  localparam logic [B_W-1:0] B_MIN = 13'h0003;
  localparam logic [A_W-1:0] A_RST = 6'h00;
  localparam logic [6:0] PRESC_BASE = 7'h08;
  localparam int CLK_PERIOD_NS = 40;
  localparam int LOCK_SET_NS = 15;
  localparam int LOCK_LOSE_NS = 25;
  localparam int LOCK_SET_INT = LOCK_SET_NS / CLK_PERIOD_NS;
  localparam logic [7:0] LOCK_SET_CYC = (LOCK_SET_INT < 1) ? 8'h01 : 8'(LOCK_SET_INT);
  localparam logic [7:0] LOCK_LOSE_CYC = 8'(LOCK_LOSE_NS / CLK_PERIOD_NS);
  localparam logic [2:0] LOCK_CNT_LO = 3'h3;
  localparam logic [2:0] LOCK_CNT_HI = 3'h5;
  localparam int SCLK_HALF_NS = 80;
  localparam int SCLK_HALF_INT = (SCLK_HALF_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam logic [3:0] SCLK_HALF_CYC = (SCLK_HALF_INT < 1) ? 4'h1 : 4'(SCLK_HALF_INT);
  localparam logic [3:0] ADDR_WORD = 4'h0;
  localparam logic [3:0] ADDR_CTRL = 4'h4;
  localparam int CTRL_START_BIT = 0;
  localparam int CTRL_CE_BIT = 1;
  localparam int STAT_BUSY_BIT = 0;
  localparam int STAT_REJECT_BIT = 1;

  typedef enum logic [1:0] {
    SEL_REF = 2'h0,
    SEL_AB = 2'h1,
    SEL_FUNC = 2'h2,
    SEL_INIT = 2'h3
  } latch_sel_t;

  typedef enum logic [2:0] {
    MON_OFF = 3'h0,
    MON_DLOCK = 3'h1,
    MON_NDIV = 3'h2,
    MON_HIGH = 3'h3,
    MON_RDIV = 3'h4,
    MON_ALOCK = 3'h5,
    MON_SDO = 3'h6,
    MON_LOW = 3'h7
  } mon_sel_t;
endpackage

// file: pll_link_if.sv
// three-wire programming link plus chip enable between host and synthesizer
interface pll_link_if;
  logic sclk;
  logic sdata;
  logic load_strobe;
  logic chip_enable;
  modport device (input sclk, input sdata, input load_strobe, input chip_enable);
  modport host (output sclk, output sdata, output load_strobe, output chip_enable);
endinterface

// file: pll_device.sv
// synthesizer digital section: serial latches, dividers, phase compare, lock, monitor mux
module pll_device import pll_pkg::*; (
  input wire logic clk_i,
  input wire logic nrst_i,
  pll_link_if.device link,
  input wire logic reference_input_i,
  input wire logic rf_input_i,
  output logic ref_isolate_switch_o,
  output logic monitor_output_o,
  output logic monitor_output_oe_n_o,
  output logic lock_detect_o,
  output logic pfd_up_o,
  output logic pfd_down_o,
  output logic power_down_o
);

  logic sclk_q, strobe_q, ref_q, rf_q;
  logic sclk_rise, strobe_rise, ref_rise, rf_rise;
  logic [WORD_W-1:0] shift_q;
  logic [R_W-1:0] ref_div_q;
  logic [1:0] backlash_q;
  logic lock_prec_q;
  logic [A_W-1:0] a_q;
  logic [B_W-1:0] b_q;
  logic [1:0] presc_q;
  logic pd1_q, pd2_q, div_reset_q;
  logic [2:0] mon_sel_q;
  logic pd_q, cnt_hold;
  logic [R_W-1:0] r_cnt_q;
  logic ref_pulse;
  logic [6:0] p_val, pre_top, pre_cnt_q;
  logic pre_pulse, n_pulse;
  logic [A_W-1:0] a_rem_q;
  logic [B_W-1:0] b_rem_q;
  logic pend_ref_q, pend_n_q, arr_ref, arr_n, pfd_evt;
  logic [7:0] err_cnt_q;
  logic [2:0] abl_q;
  logic [2:0] good_q, good_need;
  logic lock_q;
  logic mon_q, mon_oe_n_q;

  // inputs are synchronous to clk_i, so edges come from one stage of history
  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      sclk_q <= 1'b0;
      strobe_q <= 1'b0;
      ref_q <= 1'b0;
      rf_q <= 1'b0;
    end else begin
      sclk_q <= link.sclk;
      strobe_q <= link.load_strobe;
      ref_q <= reference_input_i;
      rf_q <= rf_input_i;
    end
  end
  assign sclk_rise = link.sclk & ~sclk_q;
  assign strobe_rise = link.load_strobe & ~strobe_q;
  assign ref_rise = reference_input_i & ~ref_q;
  assign rf_rise = rf_input_i & ~rf_q;

  // shifter ignores power-down so software can always reprogram
  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      shift_q <= '0;
    end else if (sclk_rise) begin
      shift_q <= {shift_q[WORD_W-2:0], link.sdata};
    end
  end

  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      ref_div_q <= REF_DIV_RST;
      backlash_q <= 2'h0;
      lock_prec_q <= 1'b0;
      a_q <= A_RST;
      b_q <= B_RST;
      presc_q <= 2'h0;
      pd1_q <= 1'b0;
      pd2_q <= 1'b0;
      div_reset_q <= 1'b0;
      mon_sel_q <= 3'h0;
    end else if (strobe_rise) begin
      unique case (latch_sel_t'(shift_q[1:0]))
        SEL_REF: begin
          ref_div_q <= shift_q[REF_DIV_LSB +: R_W];
          backlash_q <= shift_q[BACKLASH_LSB +: 2];
          lock_prec_q <= shift_q[LOCK_PREC_BIT];
        end
        SEL_AB: begin
          a_q <= shift_q[A_LSB +: A_W];
          b_q <= shift_q[B_LSB +: B_W];
        end
        SEL_FUNC, SEL_INIT: begin
          presc_q <= shift_q[PRESC_LSB +: 2];
          pd2_q <= shift_q[PD2_BIT];
          pd1_q <= shift_q[PD1_BIT];
          div_reset_q <= shift_q[DIV_RESET_BIT];
          mon_sel_q <= shift_q[MON_LSB +: 3];
        end
      endcase
    end
  end

  // synchronous mode waits for a compare event so the loop sees no frequency jump
  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      pd_q <= 1'b0;
    end else if (!link.chip_enable) begin
      pd_q <= 1'b1;
    end else if (!pd1_q) begin
      pd_q <= 1'b0;
    end else if (!pd2_q || pfd_evt) begin
      pd_q <= 1'b1;
    end
  end
  assign cnt_hold = pd_q | div_reset_q;
  assign ref_isolate_switch_o = pd_q;
  assign power_down_o = pd_q;

  // reference divider: terminal count every R edges, R=1 pulses on every edge
  assign ref_pulse = ref_rise & (r_cnt_q == '0) & ~cnt_hold;
  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      r_cnt_q <= '0;
    end else if (cnt_hold) begin
      r_cnt_q <= R_W'(ref_div_q - 14'h1);
    end else if (ref_rise) begin
      r_cnt_q <= (r_cnt_q == '0) ? R_W'(ref_div_q - 14'h1) : R_W'(r_cnt_q - 14'h1);
    end
  end

  // prescaler counts P+1 rf edges while the swallow counter is nonzero
  assign p_val = PRESC_BASE << presc_q;
  assign pre_top = (a_rem_q != '0) ? p_val : 7'(p_val - 7'h1);
  assign pre_pulse = rf_rise & (pre_cnt_q == pre_top) & ~cnt_hold;
  assign n_pulse = pre_pulse & (b_rem_q <= 13'h1);

  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      pre_cnt_q <= '0;
    end else if (cnt_hold) begin
      pre_cnt_q <= '0;
    end else if (rf_rise) begin
      pre_cnt_q <= pre_pulse ? 7'h0 : 7'(pre_cnt_q + 7'h1);
    end
  end

  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      a_rem_q <= A_RST;
      b_rem_q <= B_RST;
    end else if (cnt_hold || n_pulse) begin
      a_rem_q <= a_q;
      b_rem_q <= b_q;
    end else if (pre_pulse) begin
      b_rem_q <= B_W'(b_rem_q - 13'h1);
      if (a_rem_q != '0) begin
        a_rem_q <= A_W'(a_rem_q - 6'h1);
      end
    end
  end

  // phase compare: first arrival opens a window, error is its length in cycles
  assign arr_ref = ref_pulse | pend_ref_q;
  assign arr_n = n_pulse | pend_n_q;
  assign pfd_evt = ~pd_q & arr_ref & arr_n;

  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      pend_ref_q <= 1'b0;
      pend_n_q <= 1'b0;
      err_cnt_q <= '0;
    end else if (cnt_hold || pfd_evt) begin
      // an arrival from before a divider reset must not pair with a later one
      pend_ref_q <= 1'b0;
      pend_n_q <= 1'b0;
      err_cnt_q <= '0;
    end else begin
      pend_ref_q <= arr_ref;
      pend_n_q <= arr_n;
      if ((arr_ref || arr_n) && err_cnt_q != 8'hff) begin
        err_cnt_q <= 8'(err_cnt_q + 8'h1);
      end
    end
  end

  // both pump outputs overlap after each event; width is backlash code plus one
  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      abl_q <= '0;
    end else if (pd_q) begin
      abl_q <= '0;
    end else if (pfd_evt) begin
      abl_q <= 3'(backlash_q) + 3'h1;
    end else if (abl_q != '0) begin
      abl_q <= 3'(abl_q - 3'h1);
    end
  end
  assign pfd_up_o = pend_ref_q | (abl_q != '0);
  assign pfd_down_o = pend_n_q | (abl_q != '0);

  assign good_need = lock_prec_q ? LOCK_CNT_HI : LOCK_CNT_LO;
  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      good_q <= '0;
      lock_q <= 1'b0;
    end else if (cnt_hold) begin
      // a divider reset restarts lock qualification just as power-down does
      good_q <= '0;
      lock_q <= 1'b0;
    end else if (pfd_evt) begin
      if (err_cnt_q < LOCK_SET_CYC) begin
        if (good_q != LOCK_CNT_HI) begin
          good_q <= 3'(good_q + 3'h1);
        end
        if (3'(good_q + 3'h1) >= good_need) begin
          lock_q <= 1'b1;
        end
      end else begin
        good_q <= '0;
        if (err_cnt_q > LOCK_LOSE_CYC) begin
          lock_q <= 1'b0;
        end
      end
    end
  end
  assign lock_detect_o = lock_q;

  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      mon_q <= 1'b0;
      mon_oe_n_q <= 1'b1;
    end else begin
      mon_q <= 1'b0;
      mon_oe_n_q <= 1'b0;
      unique case (mon_sel_t'(mon_sel_q))
        MON_OFF: mon_oe_n_q <= 1'b1;
        MON_DLOCK: mon_q <= lock_q;
        MON_NDIV: mon_q <= n_pulse;
        MON_HIGH: mon_q <= 1'b1;
        MON_RDIV: mon_q <= ref_pulse;
        // pulls low only while a pump output is on; locked leaves just the backlash pulse
        MON_ALOCK: mon_oe_n_q <= ~(pfd_up_o | pfd_down_o);
        MON_SDO: mon_q <= shift_q[WORD_W-1];
        MON_LOW: mon_q <= 1'b0;
      endcase
    end
  end
  assign monitor_output_o = mon_q;
  assign monitor_output_oe_n_o = mon_oe_n_q;

endmodule

// file: pll_host.sv
// programming host: avalon-mm registers, word checks and three-wire serializer
module pll_host import pll_pkg::*; (
  input wire logic clk_i,
  input wire logic nrst_i,
  input wire logic [3:0] address_i,
  input wire logic read_i,
  input wire logic write_i,
  input wire logic [31:0] writedata_i,
  output logic [31:0] readdata_o,
  output logic waitrequest_o,
  pll_link_if.host link
);

  typedef enum logic [3:0] {
    H_IDLE = 4'b0001,
    H_LOW = 4'b0010,
    H_HIGH = 4'b0100,
    H_STROBE = 4'b1000
  } hstate_t;

  hstate_t st_q;
  logic ack_q, wr_go, rd_go, start_req, word_ok, reject_q;
  logic [WORD_W-1:0] word_q;
  logic [1:0] p_sel_q;
  logic [4:0] bit_q;
  logic [3:0] tick_q;
  logic [31:0] rdata_q;
  logic sclk_q, sdata_q, strobe_q, ce_q;
  logic [6:0] p_val;
  logic [B_W-1:0] w_b;
  logic [A_W-1:0] w_a;
  logic [21:0] w_n;
  logic [13:0] w_min;

  // one wait cycle per access; the access completes on the second edge
  assign waitrequest_o = (read_i | write_i) & ~ack_q;
  assign wr_go = write_i & ack_q;
  assign rd_go = read_i & ack_q;
  assign start_req = wr_go & (address_i == ADDR_CTRL) & writedata_i[CTRL_START_BIT];

  // ab words are checked against the last prescaler sent
  assign p_val = PRESC_BASE << p_sel_q;
  assign w_b = word_q[B_LSB +: B_W];
  assign w_a = word_q[A_LSB +: A_W];
  assign w_n = 22'(w_b * p_val) + 22'(w_a);
  assign w_min = 14'(p_val * p_val) - 14'(p_val);
  assign word_ok = (latch_sel_t'(word_q[1:0]) != SEL_AB) ||
                   ((w_b >= B_MIN) && (w_n >= 22'(w_min)));

  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      ack_q <= 1'b0;
      rdata_q <= '0;
    end else begin
      ack_q <= (read_i | write_i) & ~ack_q;
      if (read_i && !ack_q) begin
        rdata_q <= '0;
        if (address_i == ADDR_WORD) begin
          rdata_q[WORD_W-1:0] <= word_q;
        end else if (address_i == ADDR_CTRL) begin
          rdata_q[STAT_BUSY_BIT] <= (st_q != H_IDLE);
          rdata_q[STAT_REJECT_BIT] <= reject_q;
          rdata_q[CTRL_CE_BIT + 2] <= ce_q;
        end
      end
    end
  end
  assign readdata_o = rd_go ? rdata_q : 32'h0;

  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      word_q <= '0;
      ce_q <= 1'b0;
    end else if (wr_go) begin
      // the word is frozen while a transfer runs
      if (address_i == ADDR_WORD && st_q == H_IDLE) begin
        word_q <= writedata_i[WORD_W-1:0];
      end
      if (address_i == ADDR_CTRL) begin
        ce_q <= writedata_i[CTRL_CE_BIT];
      end
    end
  end

  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      st_q <= H_IDLE;
      bit_q <= '0;
      tick_q <= '0;
      sclk_q <= 1'b0;
      sdata_q <= 1'b0;
      strobe_q <= 1'b0;
      reject_q <= 1'b0;
      p_sel_q <= 2'h0;
    end else begin
      unique case (st_q)
        H_IDLE: begin
          strobe_q <= 1'b0;
          if (start_req) begin
            reject_q <= ~word_ok;
            if (word_ok) begin
              st_q <= H_LOW;
              bit_q <= 5'(WORD_W - 1);
              tick_q <= SCLK_HALF_CYC;
              sdata_q <= word_q[WORD_W-1];
              if (word_q[1]) begin
                p_sel_q <= word_q[PRESC_LSB +: 2];
              end
            end
          end
        end
        H_LOW: begin
          if (tick_q == 4'h1) begin
            sclk_q <= 1'b1;
            tick_q <= SCLK_HALF_CYC;
            st_q <= H_HIGH;
          end else begin
            tick_q <= 4'(tick_q - 4'h1);
          end
        end
        H_HIGH: begin
          if (tick_q == 4'h1) begin
            sclk_q <= 1'b0;
            tick_q <= SCLK_HALF_CYC;
            if (bit_q == '0) begin
              strobe_q <= 1'b1;
              st_q <= H_STROBE;
            end else begin
              bit_q <= 5'(bit_q - 5'h1);
              sdata_q <= word_q[5'(bit_q - 5'h1)];
              st_q <= H_LOW;
            end
          end else begin
            tick_q <= 4'(tick_q - 4'h1);
          end
        end
        H_STROBE: begin
          if (tick_q == 4'h1) begin
            strobe_q <= 1'b0;
            st_q <= H_IDLE;
          end else begin
            tick_q <= 4'(tick_q - 4'h1);
          end
        end
      endcase
    end
  end

  assign link.sclk = sclk_q;
  assign link.sdata = sdata_q;
  assign link.load_strobe = strobe_q;
  assign link.chip_enable = ce_q;

endmodule

// file: pll_link_asserts.sv
// timing checks on the three-wire programming link between host and synthesizer
module pll_link_asserts (
  input wire logic clk_i,
  input wire logic nrst_i,
  input wire logic sclk,
  input wire logic sdata,
  input wire logic load_strobe,
  input wire logic chip_enable
);
  logic [4:0] bits_q;

  // bits shifted since the last strobe; a short frame would load a half-built word
  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      bits_q <= 5'h00;
    end else if (load_strobe) begin
      bits_q <= 5'h00;
    end else if ($rose(sclk)) begin
      bits_q <= bits_q + 5'h01;
    end
  end

  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (!nrst_i);

  sequence high_phase;
    sclk [*2] ##1 !sclk;
  endsequence

  sequence strobe_pulse;
    load_strobe [*2] ##1 !load_strobe;
  endsequence

  chk_sclk_high: assert property ($rose(sclk) |-> high_phase)
    else $error("serial clock high phase is not two cycles");
  chk_sclk_low: assert property ($fell(sclk) && !load_strobe |-> !sclk [*2])
    else $error("serial clock low phase shorter than two cycles");
  chk_data_hold: assert property (sclk |-> $stable(sdata))
    else $error("serial data moved while serial clock high");
  chk_strobe_idle: assert property (load_strobe |-> !sclk)
    else $error("serial clock high during load strobe");
  chk_strobe_len: assert property ($rose(load_strobe) |-> strobe_pulse)
    else $error("load strobe is not a two cycle pulse");
  chk_strobe_edge: assert property ($rose(load_strobe) |-> $fell(sclk))
    else $error("load strobe did not rise with the last clock fall");
  chk_word_len: assert property ($rose(load_strobe) |-> bits_q == 5'h18)
    else $error("load strobe after a word that is not 24 bits");
  chk_bit_bound: assert property (bits_q <= 5'h18)
    else $error("more than 24 bits shifted before a strobe");

  cov_power_off: cover property ($fell(chip_enable));
endmodule

// file: pll_divider_serial_control_tb.sv
// self-checking bench: host and synthesizer joined over the programming link
module pll_divider_serial_control_tb import pll_pkg::*;;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk_i = 1'b0;
  logic nrst_i = 1'b0;
  logic [3:0] address = 4'h0;
  logic read = 1'b0;
  logic write = 1'b0;
  logic [31:0] writedata = 32'h0;
  logic [31:0] readdata;
  logic waitrequest;
  logic rf_in = 1'b0;
  logic ref_in = 1'b0;
  logic ph_q = 1'b0;
  logic hold_ref = 1'b0;
  logic ce = 1'b0;
  logic iso, mon, mon_oe_n, lock, up, down, pd;
  logic [23:0] cap_q = 24'h0;
  logic sclk_d = 1'b0;
  logic up_d = 1'b0;
  int n_ev = 0;
  int cyc = 0;
  int t_last = 0;
  int t_prev = 0;
  int w_q = 0;
  int last_w = 0;
  int n_mismatch = 0;
  int checked = 0;

  pll_link_if pll_link_if_inst ();
  pll_host pll_host_inst (.clk_i(clk_i), .nrst_i(nrst_i), .address_i(address), .read_i(read),
    .write_i(write), .writedata_i(writedata), .readdata_o(readdata),
    .waitrequest_o(waitrequest), .link(pll_link_if_inst));
  pll_device pll_device_inst (.clk_i(clk_i), .nrst_i(nrst_i), .link(pll_link_if_inst),
    .reference_input_i(ref_in), .rf_input_i(rf_in), .ref_isolate_switch_o(iso),
    .monitor_output_o(mon), .monitor_output_oe_n_o(mon_oe_n), .lock_detect_o(lock),
    .pfd_up_o(up), .pfd_down_o(down), .power_down_o(pd));
  pll_link_asserts pll_link_asserts_inst (.clk_i(clk_i), .nrst_i(nrst_i),
    .sclk(pll_link_if_inst.sclk), .sdata(pll_link_if_inst.sdata),
    .load_strobe(pll_link_if_inst.load_strobe), .chip_enable(pll_link_if_inst.chip_enable));

  initial begin
    forever #20 clk_i = ~clk_i;
  end

  // rf and reference share one wave so both dividers see the same edges
  always @(posedge clk_i) begin
    cyc <= cyc + 1;
    ph_q <= ~ph_q;
    if (ph_q) begin
      // rf at a quarter of the clock keeps the prescaler output far below its limit
      rf_in <= ~rf_in;
      if (!hold_ref) ref_in <= ~rf_in;
    end
    sclk_d <= pll_link_if_inst.sclk;
    if (pll_link_if_inst.sclk && !sclk_d) cap_q <= {cap_q[22:0], pll_link_if_inst.sdata};
    up_d <= up;
    if (up && !up_d) begin
      n_ev <= n_ev + 1;
      t_prev <= t_last;
      t_last <= cyc;
    end
    w_q <= up ? w_q + 1 : 0;
    if (!up && up_d) last_w <= w_q;
    if (cyc == 20000) begin
      n_mismatch++;
      stop_test();
    end
  end

  task stop_test();
    $display("checks %0d mismatches %0d", checked, n_mismatch);
    if (n_mismatch == 0 && checked > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask

  task chk(input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task wait_cyc(input int n);
    repeat (n) @(posedge clk_i);
  endtask

  // one avalon access; the request holds until waitrequest is sampled low
  task av(input logic [3:0] a, input logic wr, input logic [31:0] d, output logic [31:0] q);
    int n;
    n = 0;
    @(posedge clk_i);
    address <= a;
    write <= wr;
    read <= ~wr;
    writedata <= d;
    @(posedge clk_i);
    while (waitrequest !== 1'b0 && n < 40) begin
      @(posedge clk_i);
      n++;
    end
    if (n >= 40) n_mismatch++;
    q = readdata;
    write <= 1'b0;
    read <= 1'b0;
  endtask

  task send(input logic [23:0] w, input logic rej);
    logic [31:0] q;
    int n;
    av(ADDR_WORD, 1'b1, 32'(w), q);
    av(ADDR_CTRL, 1'b1, {30'h0, ce, 1'b1}, q);
    n = 0;
    q = 32'h1;
    while (q[STAT_BUSY_BIT] !== 1'b0 && n < 200) begin
      av(ADDR_CTRL, 1'b0, 32'h0, q);
      n++;
    end
    if (n >= 200) n_mismatch++;
    chk(q[STAT_REJECT_BIT], rej);
    if (!rej) chk(cap_q, w);
    wait_cyc(2);
  endtask

  task set_ce(input logic v);
    logic [31:0] q;
    ce = v;
    av(ADDR_CTRL, 1'b1, {30'h0, v, 1'b0}, q);
    wait_cyc(3);
  endtask

  function automatic logic [23:0] ab(input int b, input int a);
    return 24'((b << 8) | (a << 2) | 1);
  endfunction

  // divider reset aligns both counters, so every compare event has zero error
  task lock_run(input logic p, input int exp);
    int base;
    int n;
    send(24'h000016, 1'b0);
    send(24'h0200e0 | (24'(p) << 20), 1'b0);
    send(ab(7, 0), 1'b0);
    chk(lock, 1'b0);
    base = n_ev;
    send(24'h000012, 1'b0);
    n = 0;
    while (lock !== 1'b1 && n < 3000) begin
      @(posedge clk_i);
      n++;
    end
    wait_cyc(2);
    chk(n_ev - base, exp);
    chk(mon, 1'b1);
    chk(t_last - t_prev, 224);
    chk(last_w, 3);
  endtask

  initial begin
    logic [31:0] q;
    int n;
    int p;
    int codes[3];
    codes = '{7, 0, 3};
    wait_cyc(4);
    nrst_i <= 1'b1;
    wait_cyc(3);
    chk(pd, 1'b1);
    chk(iso, 1'b1);
    chk(mon_oe_n, 1'b1);
    chk(lock, 1'b0);
    av(4'h8, 1'b1, 32'hffffffff, q);
    av(4'h8, 1'b0, 32'h0, q);
    chk(q, 32'h0);
    set_ce(1'b1);
    chk(pd, 1'b0);
    chk(iso, 1'b0);
    $display("test reset and enable done");
    for (int s = 2; s < 4; s++) begin
      foreach (codes[i]) begin
        send(24'(s + (codes[i] << 4)), 1'b0);
        chk(mon_oe_n, codes[i] == 0);
        if (codes[i] != 0) chk(mon, codes[i] == 3);
      end
    end
    send(24'h000070, 1'b0);
    send(ab(7, 28), 1'b0);
    chk(mon, 1'b1);
    $display("test latch select done");
    send(ab(2, 63), 1'b1);
    send(ab(3, 63), 1'b0);
    for (int c = 0; c < 4; c++) begin
      p = 8 << c;
      send((24'(c) << 22) | 24'h000002, 1'b0);
      send(ab(p - 1, 0), 1'b0);
      send(ab(p - 2, p - 1), 1'b1);
    end
    $display("test counter limits done");
    // the second run starts locked, so its divider reset has to drop lock
    lock_run(1'b0, 3);
    lock_run(1'b1, 5);
    // the held reference loses one edge: a lasting error of one rf period
    hold_ref <= 1'b1;
    wait_cyc(2);
    hold_ref <= 1'b0;
    n = 0;
    while (lock !== 1'b0 && n < 600) begin
      @(posedge clk_i);
      n++;
    end
    wait_cyc(2);
    chk(lock, 1'b0);
    chk(mon, 1'b0);
    $display("test lock detect done");
    send(24'h000052, 1'b0);
    n = 0;
    while (up !== 1'b1 && n < 600) begin
      @(posedge clk_i);
      n++;
    end
    wait_cyc(1);
    chk(mon_oe_n, 1'b0);
    chk(mon, 1'b0);
    wait_cyc(6);
    chk(mon_oe_n, 1'b1);
    $display("test analog lock done");
    set_ce(1'b0);
    chk(pd, 1'b1);
    chk(lock, 1'b0);
    chk(iso, 1'b1);
    set_ce(1'b1);
    send(24'h00000a, 1'b0);
    chk(pd, 1'b1);
    send(24'h000002, 1'b0);
    chk(pd, 1'b0);
    // synchronous mode powers down at the next compare event
    send(24'h20000a, 1'b0);
    n = 0;
    while (pd !== 1'b1 && n < 600) begin
      @(posedge clk_i);
      n++;
    end
    chk(pd, 1'b1);
    send(24'h000002, 1'b0);
    chk(pd, 1'b0);
    $display("test power down done");
    stop_test();
  end
endmodule
